/* design/dcff_pkg.sv */
// Constants shared by the flag-timed FIFO block
package dcff_pkg;

	// Storage geometry
	localparam int unsigned DATA_W   = 9;
	localparam int unsigned ADDR_W   = 9;
	localparam int unsigned CNT_W    = 10;
	localparam logic [9:0]  DEPTH    = 10'h0200;

	// Pin bundle layout after synchronisation
	localparam int unsigned PIN_W    = 16;
	localparam int unsigned P_WCLK   = 0;
	localparam int unsigned P_RCLK   = 1;
	localparam int unsigned P_WRITE_ENABLE_PRIMARY_N = 2;
	localparam int unsigned P_WEN2LD = 3;
	localparam int unsigned P_READ_ENABLE_PRIMARY_N = 4;
	localparam int unsigned P_READ_ENABLE_SECONDARY_N = 5;
	localparam int unsigned P_OE_N   = 6;
	localparam int unsigned P_DATA   = 7;

	// Register bus
	localparam int unsigned BUS_AW   = 4;
	localparam int unsigned BUS_DW   = 32;
	localparam logic [3:0]  REG_STATUS      = 4'h0;
	localparam logic [3:0]  REG_COUNT       = 4'h4;
	localparam logic [3:0]  REG_EMPTY_OFFS  = 4'h8;
	localparam logic [3:0]  REG_FULL_OFFS   = 4'hC;

	// Status register bit positions
	localparam int unsigned ST_EMPTY_N  = 0;
	localparam int unsigned ST_FULL_N   = 1;
	localparam int unsigned ST_AEMPTY_N = 2;
	localparam int unsigned ST_AFULL_N  = 3;
	localparam int unsigned ST_LOADMODE = 4;
	localparam int unsigned ST_READY    = 5;

	// Reset values and strap wait count
	localparam logic [8:0]  EMPTY_OFFS_RST = 9'h007;
	localparam logic [8:0]  FULL_OFFS_RST  = 9'h007;
	localparam logic [1:0]  STRAP_WAIT     = 2'h3;

	// Start-up phases
	typedef enum logic [1:0] {
		DCFF_ST_STRAP = 2'b01,
		DCFF_ST_RUN   = 2'b10
	} dcff_phase_t;

endpackage

/* design/dcff_core.sv */
// Nine-bit FIFO with edge-timed flags, sampled write and read clock pins
`timescale 1ns/1ps
// Summary of operation
// R1: Full flag releases on the write edge after a read frees room.
// R2: Empty flag releases on the read edge after a write stores data.
// R3: Clock pins may keep toggling while reset is held.
// R4: After reset data outputs are low when enabled, released when disabled.
// R5: Shared pin level during reset picks second write enable or offset load.
// R6: First read at empty boundary completes within about one read period.
// R7: First word appears on the read edge after the empty flag rises.
// R8: Almost-empty flag changes only on read clock edges.
// R9: Almost-empty goes low when n-1 or fewer words remain.
// R10: Almost-full goes low when the FIFO is m-1 words short of full.
// R11: Almost-full threshold is depth minus offset.
// R12: Almost-full flag changes only on write clock edges.
// R13: Both write enables store a word; both read enables fetch one.
// R14: Flags active low; writes ignored when full, reads when empty.
module dcff_core (
	// Clock and reset
	input  wire logic                       CORE_CLK_I,
	input  wire logic                       RST_N_I,
	// Write side pins
	input  wire logic                       WRITE_CLK_I,
	input  wire logic                       WRITE_ENABLE_PRIMARY_N_I,
	input  wire logic                       WRITE_ENABLE_OR_OFFSET_LOAD_I,
	input  wire logic [dcff_pkg::DATA_W-1:0] DATA_I,
	// Read side pins
	input  wire logic                       READ_CLK_I,
	input  wire logic                       READ_ENABLE_PRIMARY_N_I,
	input  wire logic                       READ_ENABLE_SECONDARY_N_I,
	input  wire logic                       OUTPUT_ENABLE_N_I,
	output logic      [dcff_pkg::DATA_W-1:0] DATA_O,
	output logic                            DATA_OE_O,
	// Flags
	output logic                            EMPTY_FLAG_N_O,
	output logic                            FULL_FLAG_N_O,
	output logic                            ALMOST_EMPTY_FLAG_N_O,
	output logic                            ALMOST_FULL_FLAG_N_O,
	// Register bus
	input  wire logic [dcff_pkg::BUS_AW-1:0] ADDR_I,
	input  wire logic [dcff_pkg::BUS_DW-1:0] WDATA_I,
	input  wire logic                       WR_I,
	input  wire logic                       RD_I,
	output logic      [dcff_pkg::BUS_DW-1:0] RDATA_O
);

	// Bitwise filter: a bit moves once stages two and three agree
	function automatic logic [dcff_pkg::PIN_W-1:0] agree_filter(
		input logic [dcff_pkg::PIN_W-1:0] s2,
		input logic [dcff_pkg::PIN_W-1:0] s3,
		input logic [dcff_pkg::PIN_W-1:0] held
	);
		agree_filter = (s2 & s3) | (held & (s2 | s3));
	endfunction

	// Next storage address, wrapping at the array end
	function automatic logic [dcff_pkg::ADDR_W-1:0] ptr_next(
		input logic [dcff_pkg::ADDR_W-1:0] ptr
	);
		ptr_next = ptr + 9'h001;
	endfunction

	logic [dcff_pkg::PIN_W-1:0]  pins;
	logic [dcff_pkg::PIN_W-1:0]  s1_q;
	logic [dcff_pkg::PIN_W-1:0]  s2_q;
	logic [dcff_pkg::PIN_W-1:0]  s3_q;
	logic [dcff_pkg::PIN_W-1:0]  filt_q;
	logic [dcff_pkg::PIN_W-1:0]  filt_d;
	logic                        wclk_rise;
	logic                        rclk_rise;
	logic [dcff_pkg::DATA_W-1:0] wdata;
	dcff_pkg::dcff_phase_t       phase_q;
	logic [1:0]                  wait_q;
	logic                        load_mode_q;
	logic                        load_sel_q;
	logic [dcff_pkg::DATA_W-1:0] mem [0:511];
	logic [dcff_pkg::ADDR_W-1:0] wr_ptr_q;
	logic [dcff_pkg::ADDR_W-1:0] rd_ptr_q;
	logic [dcff_pkg::CNT_W-1:0]  count_q;
	logic [dcff_pkg::CNT_W-1:0]  count_d;
	logic [8:0]                  empty_offs_q;
	logic [8:0]                  full_offs_q;
	logic                        running;
	logic                        wr_en;
	logic                        ld_en;
	logic                        rd_en;
	logic                        wr_ok;
	logic                        rd_ok;
	logic                        empty_flag_n_q;
	logic                        full_flag_n_q;
	logic                        almost_empty_flag_n_q;
	logic                        almost_full_flag_n_q;
	logic [dcff_pkg::DATA_W-1:0] data_q;
	logic                        data_oe_q;
	logic [dcff_pkg::BUS_DW-1:0] rdata_q;
	logic [dcff_pkg::BUS_DW-1:0] status_word;
	logic                        bus_empty_wr;
	logic                        bus_full_wr;
	logic                        pin_load;

	// Gather every pin into one bundle
	assign pins = {DATA_I, OUTPUT_ENABLE_N_I, READ_ENABLE_SECONDARY_N_I,
		READ_ENABLE_PRIMARY_N_I, WRITE_ENABLE_OR_OFFSET_LOAD_I,
		WRITE_ENABLE_PRIMARY_N_I, READ_CLK_I, WRITE_CLK_I};

	// Three-stage synchroniser; pins keep running through reset
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin // see R3
		if (!RST_N_I) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Filtered pin levels
	assign filt_d = agree_filter(s2_q, s3_q, filt_q);

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			filt_q <= '0;
		end else begin
			filt_q <= filt_d;
		end
	end

	// Sampled clock edges and qualified enables
	assign wclk_rise = filt_d[dcff_pkg::P_WCLK] & ~filt_q[dcff_pkg::P_WCLK];
	assign rclk_rise = filt_d[dcff_pkg::P_RCLK] & ~filt_q[dcff_pkg::P_RCLK];
	assign wdata     = filt_d[dcff_pkg::P_DATA +: dcff_pkg::DATA_W];
	assign running   = (phase_q == dcff_pkg::DCFF_ST_RUN);
	assign wr_en     = ~filt_d[dcff_pkg::P_WRITE_ENABLE_PRIMARY_N]
		& (load_mode_q | filt_d[dcff_pkg::P_WEN2LD]); // see R13
	assign ld_en     = ~filt_d[dcff_pkg::P_WRITE_ENABLE_PRIMARY_N] & load_mode_q
		& ~filt_d[dcff_pkg::P_WEN2LD];
	assign rd_en     = ~filt_d[dcff_pkg::P_READ_ENABLE_PRIMARY_N] & ~filt_d[dcff_pkg::P_READ_ENABLE_SECONDARY_N]; // see R13
	assign wr_ok     = running & wclk_rise & wr_en & ~ld_en & full_flag_n_q; // see R14
	assign rd_ok     = running & rclk_rise & rd_en & empty_flag_n_q; // see R14 R7

	// Strap capture once the synchroniser has settled after release
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin // see R5
		if (!RST_N_I) begin
			phase_q     <= dcff_pkg::DCFF_ST_STRAP;
			wait_q      <= 2'h0;
			load_mode_q <= 1'b0;
		end else begin
			case (phase_q)
				dcff_pkg::DCFF_ST_STRAP: begin
					if (wait_q == dcff_pkg::STRAP_WAIT) begin
						load_mode_q <= ~filt_d[dcff_pkg::P_WEN2LD]; // Low level selects load
						phase_q     <= dcff_pkg::DCFF_ST_RUN;
					end else begin
						wait_q <= wait_q + 2'h1;
					end
				end
				dcff_pkg::DCFF_ST_RUN: begin
					phase_q <= dcff_pkg::DCFF_ST_RUN;
				end
				default: begin
					phase_q <= dcff_pkg::DCFF_ST_STRAP;
				end
			endcase
		end
	end

	// Storage array, written on accepted write edges
	always_ff @(posedge CORE_CLK_I) begin
		if (wr_ok) begin
			mem[wr_ptr_q] <= wdata;
		end
	end

	// Word count after this cycle's accepted write and read
	assign count_d = count_q + (wr_ok ? 10'h001 : 10'h000) - (rd_ok ? 10'h001 : 10'h000);

	// Write address, advanced on accepted writes
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_ptr_q <= '0;
		end else if (wr_ok) begin
			wr_ptr_q <= ptr_next(wr_ptr_q);
		end
	end

	// Read address, advanced on accepted reads
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_ptr_q <= '0;
		end else if (rd_ok) begin
			rd_ptr_q <= ptr_next(rd_ptr_q);
		end
	end

	// Stored word count
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	// Full flag, moved only on sampled write edges
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			full_flag_n_q <= 1'b1;
		end else if (running && wclk_rise) begin
			full_flag_n_q <= (count_d != dcff_pkg::DEPTH); // see R1 R14
		end
	end

	// Almost-full flag, moved only on sampled write edges
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			almost_full_flag_n_q <= 1'b1;
		end else if (running && wclk_rise) begin
			almost_full_flag_n_q <= ~(count_d > (dcff_pkg::DEPTH
				- {1'b0, full_offs_q})); // see R10 R11 R12
		end
	end

	// Empty flag, moved only on sampled read edges
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			empty_flag_n_q <= 1'b0;
		end else if (running && rclk_rise) begin
			empty_flag_n_q <= (count_d != 10'h000); // see R2 R6 R14
		end
	end

	// Almost-empty flag, moved only on sampled read edges
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			almost_empty_flag_n_q <= 1'b0;
		end else if (running && rclk_rise) begin
			almost_empty_flag_n_q <= ~(count_d < {1'b0, empty_offs_q}); // see R8 R9
		end
	end

	// Output word, fetched the edge after empty rises
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			data_q <= '0; // see R4
		end else if (rd_ok) begin
			data_q <= mem[rd_ptr_q]; // see R7 R6
		end
	end

	// Output enable follows the sampled pin, held off until real levels arrive
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			data_oe_q <= 1'b0;
		end else begin
			data_oe_q <= running & ~filt_d[dcff_pkg::P_OE_N]; // see R4
		end
	end

	// Offset load decode: a bus write to either offset register drops a pin load in the same cycle
	assign bus_empty_wr = WR_I & (ADDR_I == dcff_pkg::REG_EMPTY_OFFS);
	assign bus_full_wr  = WR_I & (ADDR_I == dcff_pkg::REG_FULL_OFFS);
	assign pin_load     = running & wclk_rise & ld_en & ~bus_empty_wr & ~bus_full_wr; // see R5

	// Almost-empty offset register
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			empty_offs_q <= dcff_pkg::EMPTY_OFFS_RST;
		end else if (bus_empty_wr) begin
			empty_offs_q <= WDATA_I[8:0];
		end else if (pin_load && !load_sel_q) begin
			empty_offs_q <= wdata; // see R5
		end
	end

	// Almost-full offset register
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			full_offs_q <= dcff_pkg::FULL_OFFS_RST;
		end else if (bus_full_wr) begin
			full_offs_q <= WDATA_I[8:0];
		end else if (pin_load && load_sel_q) begin
			full_offs_q <= wdata; // see R5
		end
	end

	// Pin loads alternate empty then full
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			load_sel_q <= 1'b0;
		end else if (pin_load) begin
			load_sel_q <= ~load_sel_q;
		end
	end

	// Status word built from the field positions
	always_comb begin
		status_word                        = '0;
		status_word[dcff_pkg::ST_EMPTY_N]  = empty_flag_n_q;
		status_word[dcff_pkg::ST_FULL_N]   = full_flag_n_q;
		status_word[dcff_pkg::ST_AEMPTY_N] = almost_empty_flag_n_q;
		status_word[dcff_pkg::ST_AFULL_N]  = almost_full_flag_n_q;
		status_word[dcff_pkg::ST_LOADMODE] = load_mode_q;
		status_word[dcff_pkg::ST_READY]    = running;
	end

	// Register read, answered one cycle after the strobe
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_q <= '0;
		end else if (RD_I) begin
			case (ADDR_I)
				dcff_pkg::REG_STATUS: begin
					rdata_q <= status_word;
				end
				dcff_pkg::REG_COUNT: begin
					rdata_q <= {22'h00_0000, count_q};
				end
				dcff_pkg::REG_EMPTY_OFFS: begin
					rdata_q <= {23'h00_0000, empty_offs_q};
				end
				dcff_pkg::REG_FULL_OFFS: begin
					rdata_q <= {23'h00_0000, full_offs_q};
				end
				default: begin
					rdata_q <= '0; // Unmapped reads return zero
				end
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	// Outputs straight from flip-flops
	assign DATA_O                = data_q;
	assign DATA_OE_O             = data_oe_q;
	assign EMPTY_FLAG_N_O        = empty_flag_n_q;
	assign FULL_FLAG_N_O         = full_flag_n_q;
	assign ALMOST_EMPTY_FLAG_N_O = almost_empty_flag_n_q;
	assign ALMOST_FULL_FLAG_N_O  = almost_full_flag_n_q;
	assign RDATA_O               = rdata_q;

endmodule // dcff_core

/* tb/dcff_core_sva.sv */
// Port checks for the flag-timed FIFO
`timescale 1ns/1ps
module dcff_core_chk (
	// Clock and reset
	input wire logic                        CORE_CLK_I,
	input wire logic                        RST_N_I,
	// Pin clocks
	input wire logic                        WRITE_CLK_I,
	input wire logic                        READ_CLK_I,
	// Outputs
	input wire logic [dcff_pkg::DATA_W-1:0] DATA_O,
	input wire logic                        DATA_OE_O,
	input wire logic                        EMPTY_FLAG_N_O,
	input wire logic                        FULL_FLAG_N_O,
	input wire logic                        ALMOST_EMPTY_FLAG_N_O,
	input wire logic                        ALMOST_FULL_FLAG_N_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// Reset state, flag consistency, and flags and the data output moving only a few cycles after their own pin edge
	property p_rst;
		$rose(RST_N_I) |-> !EMPTY_FLAG_N_O && FULL_FLAG_N_O && !DATA_OE_O && DATA_O == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_ff;
		$changed(FULL_FLAG_N_O) |-> $past(WRITE_CLK_I, 2) && !$past(WRITE_CLK_I, 6);
	endproperty
	a_ff: assert property (p_ff) else $error("full flag off write edge");
	property p_ef;
		$changed(EMPTY_FLAG_N_O) |-> $past(READ_CLK_I, 2) && !$past(READ_CLK_I, 6);
	endproperty
	a_ef: assert property (p_ef) else $error("empty flag off read edge");
	property p_ae;
		$changed(ALMOST_EMPTY_FLAG_N_O) |-> $past(READ_CLK_I, 2) && !$past(READ_CLK_I, 6);
	endproperty
	a_ae: assert property (p_ae) else $error("almost-empty off read edge");
	property p_af;
		$changed(ALMOST_FULL_FLAG_N_O) |-> $past(WRITE_CLK_I, 2) && !$past(WRITE_CLK_I, 6);
	endproperty
	a_af: assert property (p_af) else $error("almost-full off write edge");
	property p_dat;
		$changed(DATA_O) |-> $past(READ_CLK_I, 2) && !$past(READ_CLK_I, 6);
	endproperty
	a_dat: assert property (p_dat) else $error("data moved off read edge");
	property p_both;
		EMPTY_FLAG_N_O || FULL_FLAG_N_O;
	endproperty
	a_both: assert property (p_both) else $error("empty and full together");
	property p_eae;
		!EMPTY_FLAG_N_O |-> !ALMOST_EMPTY_FLAG_N_O;
	endproperty
	a_eae: assert property (p_eae) else $error("empty without almost-empty");
endmodule // dcff_core_chk
bind dcff_core dcff_core_chk chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
	.WRITE_CLK_I(WRITE_CLK_I), .READ_CLK_I(READ_CLK_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
	.EMPTY_FLAG_N_O(EMPTY_FLAG_N_O), .FULL_FLAG_N_O(FULL_FLAG_N_O),
	.ALMOST_EMPTY_FLAG_N_O(ALMOST_EMPTY_FLAG_N_O), .ALMOST_FULL_FLAG_N_O(ALMOST_FULL_FLAG_N_O));

/* tb/dcff_far_end.sv */
// Writer and reader with their own free-running pin clocks
`timescale 1ns/1ps
module dcff_far_end (
	// Bench controls
	input  wire logic wgo_i,
	input  wire logic rgo_i,
	// Pins
	output logic       wclk_o,
	output logic       rclk_o,
	output logic       wen_n_o,
	output logic       ren_n_o,
	output logic [8:0] wdata_o
);
	// Idle values; clocks run through reset too
	initial begin
		wclk_o = 1'b0;
		rclk_o = 1'b0;
		wen_n_o = 1'b1;
		ren_n_o = 1'b1;
		wdata_o = 9'h001;
	end
	// Whole-cycle halves: pin edges miss core rising edges; write and read rising edges never coincide
	always #60 wclk_o = ~wclk_o;
	always #70 rclk_o = ~rclk_o;
	// Enables and data set up half a period ahead
	always @(negedge wclk_o) begin
		wen_n_o <= ~wgo_i;
		wdata_o <= 9'($urandom_range(511, 1));
	end
	always @(negedge rclk_o) ren_n_o <= ~rgo_i;
endmodule // dcff_far_end

/* tb/dcff_core_tb_top.sv */
// Self-checking bench for the flag-timed FIFO
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module dcff_core_tb_top;
	logic        clk = 0, rst_n = 0, ld = 1, oe_n = 0, wr = 0, rd = 0, wgo = 0, rgo = 0;
	logic        live = 0, lmode, ph, fm, afm, em, aem, doe, ef, ff, aef, aff;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000, rdata, rv;
	logic [8:0]  din, dout, exp_d, offs[2], q[$];
	wire         wclk, rclk, wen_n, ren_n;
	int          miscompares = 0, n_compared = 0, n_off, m_off, nld, i;
	always #5 clk = ~clk;
	dcff_far_end far (.wgo_i(wgo), .rgo_i(rgo), .wclk_o(wclk), .rclk_o(rclk),
		.wen_n_o(wen_n), .ren_n_o(ren_n), .wdata_o(din));
	dcff_core uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .WRITE_CLK_I(wclk),
		.WRITE_ENABLE_PRIMARY_N_I(wen_n), .WRITE_ENABLE_OR_OFFSET_LOAD_I(ld), .DATA_I(din),
		.READ_CLK_I(rclk), .READ_ENABLE_PRIMARY_N_I(ren_n), .READ_ENABLE_SECONDARY_N_I(ren_n),
		.OUTPUT_ENABLE_N_I(oe_n), .DATA_O(dout), .DATA_OE_O(doe), .EMPTY_FLAG_N_O(ef),
		.FULL_FLAG_N_O(ff), .ALMOST_EMPTY_FLAG_N_O(aef), .ALMOST_FULL_FLAG_N_O(aff),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
	// Model write side: store, load offsets, refresh flags
	always @(posedge wclk) if (live) begin
		if (!wen_n && ld && fm) q.push_back(din);
		if (!wen_n && lmode && !ld) begin
			offs[ph] = din;
			if (ph) m_off = din;
			else n_off = din;
			ph = ~ph;
			nld++;
		end
		fm = (q.size() != 512);
		afm = !(q.size() > 512 - m_off);
	end
	// Model read side
	always @(posedge rclk) if (live) begin
		if (!ren_n && em) exp_d = q.pop_front();
		em = (q.size() != 0);
		aem = !(q.size() < n_off);
	end
	// Compare flags and data well after each pin edge
	always @(negedge wclk) if (live) begin
		`CHK(ff, fm)
		`CHK(aff, afm)
	end
	always @(negedge rclk) if (live) begin
		`CHK(ef, em)
		`CHK(aef, aem)
		`CHK(dout, exp_d)
	end
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic do_reset(input logic strap);
		live = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		ld <= strap;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		q.delete();
		{em, fm, aem, afm, exp_d, n_off, m_off, nld, ph} = {4'b0101, 9'h000, 32'd7, 32'd7, 33'd0};
		lmode = !strap;
		repeat (12) @(posedge clk);
		live = 1;
	endtask
	task automatic wait_sz(input int tgt);
		for (i = 0; i < 20000 && (lmode ? nld : q.size()) < tgt; i++) @(posedge clk);
		if ((lmode ? nld : q.size()) < tgt) results();
		repeat (40) @(posedge clk);
	endtask
	task automatic results();
		if (i >= 20000) miscompares++;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'hb9e9_ec29));
		do_reset(1'b1);
		`CHK(dout, 9'h000)
		oe_n <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK(doe, 1'b0)
		bus(1'b1, dcff_pkg::REG_EMPTY_OFFS, 32'h0000_0010);
		n_off = 16;
		bus(1'b0, dcff_pkg::REG_EMPTY_OFFS, 32'h0000_0000);
		`CHK(rv, 32'h0000_0010)
		bus(1'b0, 4'h2, 32'h0000_0000);
		`CHK(rv, 32'h0000_0000)
		bus(1'b0, dcff_pkg::REG_STATUS, 32'h0000_0000);
		`CHK(rv[5:4], 2'b10)
		oe_n <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(doe, 1'b1)
		$display("test reset and bus done");
		wgo <= 1'b1;
		wait_sz(512);
		wgo <= 1'b0;
		bus(1'b0, dcff_pkg::REG_COUNT, 32'h0000_0000);
		`CHK(rv, 32'h0000_0200)
		$display("test fill done");
		rgo <= 1'b1;
		for (i = 0; i < 20000 && q.size() != 0; i++) @(posedge clk);
		if (q.size() != 0) results();
		repeat (40) @(posedge clk);
		rgo <= 1'b0;
		bus(1'b0, dcff_pkg::REG_COUNT, 32'h0000_0000);
		`CHK(rv, 32'h0000_0000)
		$display("test drain done");
		do_reset(1'b0);
		wgo <= 1'b1;
		wait_sz(2);
		wgo <= 1'b0;
		repeat (40) @(posedge clk);
		bus(1'b0, dcff_pkg::REG_EMPTY_OFFS, 32'h0000_0000);
		`CHK(rv, {23'h0, offs[0]})
		bus(1'b0, dcff_pkg::REG_FULL_OFFS, 32'h0000_0000);
		`CHK(rv, {23'h0, offs[1]})
		$display("test offset load done");
		results();
	end
endmodule // dcff_core_tb_top
